// File: logic/ots_pkg.sv
// Purpose: Shared constants and types for the overcurrent trip test sequencer.
// Assumes: 25 MHz clock; AXI4-Lite register access with 32-bit data.
// Notes: Every offset, field position, time limit and timing figure lives here; the slot limit is SLOTS in ots_sequencer.
package ots_pkg;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_RESULT = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFS_IRQ_EN = 8'h10;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
	// Setup window: eight words that map onto the selected setup slot.
	localparam logic [7:0] OFS_SETUP_BASE = 8'h20;
	localparam logic [7:0] OFS_SETUP_LAST = 8'h3c;

	// Field index of each setup word inside a slot.
	localparam int SETUP_WORDS = 8;
	localparam logic [2:0] FLD_START = 3'h0;
	localparam logic [2:0] FLD_END = 3'h1;
	localparam logic [2:0] FLD_INC = 3'h2;
	localparam logic [2:0] FLD_LAST = 3'h3;
	localparam logic [2:0] FLD_STEP_MS = 3'h4;
	localparam logic [2:0] FLD_DELAY_MS = 3'h5;
	localparam logic [2:0] FLD_TRIGV = 3'h6;
	localparam logic [2:0] FLD_RANGE = 3'h7;

	// ************************************************************
	// Control fields and reset values
	// ************************************************************
	localparam int CTRL_TEST_EN = 0;
	localparam int CTRL_LOAD_ON = 1;
	localparam int CTRL_CC_MODE = 2;
	localparam int CTRL_SLOT_LSB = 3;
	localparam int SLOT_W = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int RES_CODE_LSB = 16;

	// ************************************************************
	// Widths, ranges and result codes
	// ************************************************************
	localparam int CUR_W = 16;
	localparam int MS_W = 21;
	localparam logic [1:0] RANGE_LOW = 2'h0;
	localparam logic [1:0] RANGE_MID = 2'h1;
	localparam logic [1:0] RANGE_HIGH = 2'h2;

	typedef enum logic [1:0] {
		RES_NONE = 2'h0,
		RES_TRIPPED = 2'h1,
		RES_TIMEOUT = 2'h2,
		RES_CFG_ERR = 2'h3
	} ots_result_t;

	// Interrupt status bit positions.
	localparam int IRQ_TRIP = 0;
	localparam int IRQ_TIMEOUT = 1;
	localparam int IRQ_CFG_ERR = 2;
	localparam int IRQ_W = 3;

	// One-hot sequencer states.
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_DELAY = 6'h02,
		ST_STEP = 6'h04,
		ST_HOLD = 6'h08,
		ST_DONE = 6'h10,
		ST_SPARE = 6'h20
	} ots_state_t;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int MS_NS = 1000000;
	localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam logic [MS_W-1:0] STEP_MS_MIN = 21'd50;
	localparam logic [MS_W-1:0] STEP_MS_MAX = 21'd1600000;
	localparam logic [MS_W-1:0] DELAY_MS_MIN = 21'd5;
	localparam logic [MS_W-1:0] DELAY_MS_MAX = 21'd160;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ots_pkg

// File: logic/ots_sequencer.sv
// Purpose: Overcurrent trip test sequencer with AXI4-Lite registers.
// Assumes: Measured voltage and current arrive synchronous to aclk.
// Notes: Setup words are read and written through the selected slot window.

// Summary of operation
// - Twelve setups are stored and a slot index picks the one edited and run.
// - Each setup selects the high, middle or low constant-current sink range.
// - The setpoint starts at the start current and rises by the increment each step.
// - Each step lasts the step time, held between 50 ms and 1600 s.
// - Stepping waits a start delay of 5 to 160 ms after the load turns on.
// - The ramp only begins while measured voltage is above the trip threshold.
// - A trip is seen when supply voltage falls below the trip threshold.
// - On a trip the setpoint of the last step is reported as the result.
// - After a trip the load keeps sinking the post-trip current.
// - Low voltage with current above the end current is a timeout failure.
// - Voltage not above threshold when the start delay ends is a configuration error.
// - The test runs only in constant-current mode, enabled, with the load on.
module ots_sequencer #(
	parameter int SLOTS = 12,
	parameter int TICK_CYCLES = ots_pkg::TICK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [ots_pkg::CUR_W-1:0] meas_voltage,
	input wire logic [ots_pkg::CUR_W-1:0] meas_current,
	output logic sink_enable,
	output logic [1:0] sink_range,
	output logic [ots_pkg::CUR_W-1:0] sink_setpoint,
	output logic irq
);
	localparam int MEM_W = SLOTS * ots_pkg::SETUP_WORDS;

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [31:0] setup_mem [MEM_W];
	logic [31:0] ctrl_r;
	logic [ots_pkg::IRQ_W-1:0] irq_stat_r;
	logic [ots_pkg::IRQ_W-1:0] irq_en_r;
	logic [ots_pkg::IRQ_W-1:0] irq_set;
	logic [ots_pkg::CUR_W-1:0] result_r;
	ots_pkg::ots_result_t code_r;
	ots_pkg::ots_state_t state_r;
	ots_pkg::ots_state_t state_nxt;
	logic [ots_pkg::CUR_W-1:0] sp_r;
	logic [ots_pkg::CUR_W:0] sp_sum;
	logic [ots_pkg::SLOT_W-1:0] slot_r;
	logic [ots_pkg::SLOT_W-1:0] run_slot_r;
	logic wr_go;
	logic [31:0] wmask;
	logic wr_setup;
	logic [2:0] wr_fld;
	logic [2:0] rd_fld;
	logic run_ok;
	logic v_above;
	logic v_below;
	logic [ots_pkg::CUR_W-1:0] c_start;
	logic [ots_pkg::CUR_W-1:0] c_end;
	logic [ots_pkg::CUR_W-1:0] c_inc;
	logic [ots_pkg::CUR_W-1:0] c_last;
	logic [ots_pkg::CUR_W-1:0] c_trigv;
	logic [ots_pkg::MS_W-1:0] c_step_ms;
	logic [ots_pkg::MS_W-1:0] c_delay_ms;
	logic [1:0] c_range;

	ots_tmr_if tmr ();

	ots_step_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) ots_step_timer_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.tmr(tmr)
	);

	// ************************************************************
	// AXI4-Lite write channel
	// ************************************************************
	// Address and data are taken together so a write never waits on a half.
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign wr_setup = (s_axi_awaddr >= ots_pkg::OFS_SETUP_BASE)
		&& (s_axi_awaddr <= ots_pkg::OFS_SETUP_LAST);
	assign wr_fld = s_axi_awaddr[4:2];

	// Byte lane mask built from the strobes, one lane per generate pass.
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_lane
			assign wmask[8*gb +: 8] = {8{s_axi_wstrb[gb]}};
		end
	endgenerate

	// Write response; unmapped and misaligned addresses answer SLVERR.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ots_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			if (wr_setup || s_axi_awaddr == ots_pkg::OFS_CTRL
				|| s_axi_awaddr == ots_pkg::OFS_IRQ_EN
				|| s_axi_awaddr == ots_pkg::OFS_IRQ_CLR
				|| s_axi_awaddr == ots_pkg::OFS_STATUS
				|| s_axi_awaddr == ots_pkg::OFS_RESULT
				|| s_axi_awaddr == ots_pkg::OFS_IRQ_STAT) begin
				s_axi_bresp <= (s_axi_awaddr[1:0] == 2'h0) ? ots_pkg::RESP_OKAY
					: ots_pkg::RESP_SLVERR;
			end else begin
				s_axi_bresp <= ots_pkg::RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control register; a slot index of twelve or more is refused.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= ots_pkg::CTRL_RESET;
			slot_r <= '0;
		end else if (wr_go && s_axi_awaddr == ots_pkg::OFS_CTRL) begin
			ctrl_r <= (ctrl_r & ~wmask) | (s_axi_wdata & wmask);
			if (s_axi_wstrb[0] && 32'(s_axi_wdata[ots_pkg::CTRL_SLOT_LSB +: ots_pkg::SLOT_W])
				< 32'(SLOTS)) begin
				slot_r <= s_axi_wdata[ots_pkg::CTRL_SLOT_LSB +: ots_pkg::SLOT_W];
			end
		end
	end

	// Setup memory: the window edits only the slot that is selected.
	always_ff @(posedge aclk) begin
		if (wr_go && wr_setup) begin
			setup_mem[{slot_r, wr_fld}] <= (setup_mem[{slot_r, wr_fld}] & ~wmask)
				| (s_axi_wdata & wmask);
		end
	end

	// ************************************************************
	// AXI4-Lite read channel
	// ************************************************************
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fld = s_axi_araddr[4:2];

	// Read data is registered; setup words read back the selected slot.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= ots_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= ots_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h0;
			if (s_axi_araddr >= ots_pkg::OFS_SETUP_BASE
				&& s_axi_araddr <= ots_pkg::OFS_SETUP_LAST) begin
				s_axi_rdata <= setup_mem[{slot_r, rd_fld}];
			end else begin
				unique case (s_axi_araddr)
					ots_pkg::OFS_CTRL: begin
						s_axi_rdata <= ctrl_r;
						s_axi_rdata[ots_pkg::CTRL_SLOT_LSB +: ots_pkg::SLOT_W] <= slot_r;
					end
					ots_pkg::OFS_STATUS: s_axi_rdata <= {26'h0, state_r};
					ots_pkg::OFS_RESULT: s_axi_rdata <= {14'h0, code_r, result_r};
					ots_pkg::OFS_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_r};
					ots_pkg::OFS_IRQ_EN: s_axi_rdata <= {29'h0, irq_en_r};
					ots_pkg::OFS_IRQ_CLR: s_axi_rdata <= 32'h0;
					default: s_axi_rresp <= ots_pkg::RESP_SLVERR;
				endcase
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ************************************************************
	// Setup of the running slot
	// ************************************************************
	// Times are clamped to their legal span so a bad setup cannot stall a step.
	always_comb begin
		c_start = setup_mem[{run_slot_r, ots_pkg::FLD_START}][ots_pkg::CUR_W-1:0];
		c_end = setup_mem[{run_slot_r, ots_pkg::FLD_END}][ots_pkg::CUR_W-1:0];
		c_inc = setup_mem[{run_slot_r, ots_pkg::FLD_INC}][ots_pkg::CUR_W-1:0];
		c_last = setup_mem[{run_slot_r, ots_pkg::FLD_LAST}][ots_pkg::CUR_W-1:0];
		c_trigv = setup_mem[{run_slot_r, ots_pkg::FLD_TRIGV}][ots_pkg::CUR_W-1:0];
		c_range = setup_mem[{run_slot_r, ots_pkg::FLD_RANGE}][1:0];
		if (c_range > ots_pkg::RANGE_HIGH) begin
			c_range = ots_pkg::RANGE_HIGH;
		end
		c_step_ms = setup_mem[{run_slot_r, ots_pkg::FLD_STEP_MS}][ots_pkg::MS_W-1:0];
		if (c_step_ms < ots_pkg::STEP_MS_MIN) begin
			c_step_ms = ots_pkg::STEP_MS_MIN;
		end else if (c_step_ms > ots_pkg::STEP_MS_MAX) begin
			c_step_ms = ots_pkg::STEP_MS_MAX;
		end
		c_delay_ms = setup_mem[{run_slot_r, ots_pkg::FLD_DELAY_MS}][ots_pkg::MS_W-1:0];
		if (c_delay_ms < ots_pkg::DELAY_MS_MIN) begin
			c_delay_ms = ots_pkg::DELAY_MS_MIN;
		end else if (c_delay_ms > ots_pkg::DELAY_MS_MAX) begin
			c_delay_ms = ots_pkg::DELAY_MS_MAX;
		end
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	assign run_ok = ctrl_r[ots_pkg::CTRL_TEST_EN] && ctrl_r[ots_pkg::CTRL_LOAD_ON]
		&& ctrl_r[ots_pkg::CTRL_CC_MODE];
	assign v_above = meas_voltage > c_trigv;
	assign v_below = meas_voltage < c_trigv;
	assign sp_sum = {1'b0, sp_r} + {1'b0, c_inc};

	// Next state; losing the enable, the load or constant-current mode aborts.
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ots_pkg::ST_IDLE: if (run_ok) state_nxt = ots_pkg::ST_DELAY;
			ots_pkg::ST_DELAY: begin
				if (tmr.expired) begin
					state_nxt = v_above ? ots_pkg::ST_STEP : ots_pkg::ST_DONE;
				end
			end
			ots_pkg::ST_STEP: begin
				if (tmr.expired && v_below) begin
					state_nxt = (meas_current > c_end) ? ots_pkg::ST_DONE
						: ots_pkg::ST_HOLD;
				end else if (tmr.expired && sp_r >= c_end) begin
					state_nxt = ots_pkg::ST_DONE;
				end
			end
			ots_pkg::ST_HOLD: state_nxt = ots_pkg::ST_HOLD;
			ots_pkg::ST_DONE: state_nxt = ots_pkg::ST_DONE;
			default: state_nxt = ots_pkg::ST_IDLE;
		endcase
		if (!run_ok) begin
			state_nxt = ots_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ots_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Timer starts: the start delay on entry, then one period per step.
	always_comb begin
		tmr.start = 1'b0;
		tmr.load_ms = c_step_ms;
		if (state_r == ots_pkg::ST_IDLE && run_ok) begin
			tmr.start = 1'b1;
			tmr.load_ms = setup_mem[{slot_r, ots_pkg::FLD_DELAY_MS}][ots_pkg::MS_W-1:0]
				< ots_pkg::DELAY_MS_MIN ? ots_pkg::DELAY_MS_MIN
				: (setup_mem[{slot_r, ots_pkg::FLD_DELAY_MS}][ots_pkg::MS_W-1:0]
				> ots_pkg::DELAY_MS_MAX ? ots_pkg::DELAY_MS_MAX
				: setup_mem[{slot_r, ots_pkg::FLD_DELAY_MS}][ots_pkg::MS_W-1:0]);
		end else if (run_ok && state_nxt == ots_pkg::ST_STEP && tmr.expired) begin
			tmr.start = 1'b1;
		end
	end

	// The running slot is frozen when the test starts.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_slot_r <= '0;
		end else if (state_r == ots_pkg::ST_IDLE) begin
			run_slot_r <= slot_r;
		end
	end

	// Sink setpoint: start value, fixed increments clipped at the end value,
	// then the post-trip value once the supply has tripped.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sp_r <= '0;
		end else if (state_nxt == ots_pkg::ST_IDLE || state_nxt == ots_pkg::ST_DONE) begin
			sp_r <= '0;
		end else if (state_r == ots_pkg::ST_DELAY && state_nxt == ots_pkg::ST_STEP) begin
			sp_r <= c_start;
		end else if (state_r == ots_pkg::ST_STEP && state_nxt == ots_pkg::ST_HOLD) begin
			sp_r <= c_last;
		end else if (state_r == ots_pkg::ST_STEP && tmr.expired) begin
			sp_r <= (sp_sum > {1'b0, c_end}) ? c_end : sp_sum[ots_pkg::CUR_W-1:0];
		end
	end

	// Sink drive follows the sequencer; range comes from the running setup.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sink_enable <= 1'b0;
			sink_range <= ots_pkg::RANGE_LOW;
			sink_setpoint <= '0;
		end else begin
			sink_enable <= (state_r == ots_pkg::ST_STEP) || (state_r == ots_pkg::ST_HOLD);
			// Idle shows the low range, since the idle slot may never have been written.
			sink_range <= (state_r == ots_pkg::ST_IDLE) ? ots_pkg::RANGE_LOW : c_range;
			sink_setpoint <= sp_r;
		end
	end

	// Result latch: one code per run, evaluated only when the start delay or a step ends.
	// The code stays readable after the load is turned off until the next start.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			code_r <= ots_pkg::RES_NONE;
			result_r <= '0;
		end else if (state_r == ots_pkg::ST_IDLE && run_ok) begin
			code_r <= ots_pkg::RES_NONE;
			result_r <= '0;
		end else if (state_r == ots_pkg::ST_DELAY && state_nxt == ots_pkg::ST_DONE) begin
			code_r <= ots_pkg::RES_CFG_ERR;
		end else if (state_r == ots_pkg::ST_STEP && state_nxt == ots_pkg::ST_HOLD) begin
			code_r <= ots_pkg::RES_TRIPPED;
			result_r <= sp_r;
		end else if (state_r == ots_pkg::ST_STEP && state_nxt == ots_pkg::ST_DONE) begin
			code_r <= ots_pkg::RES_TIMEOUT;
		end
	end

	// ************************************************************
	// Interrupts
	// ************************************************************
	assign irq_set[ots_pkg::IRQ_TRIP] = state_r == ots_pkg::ST_STEP
		&& state_nxt == ots_pkg::ST_HOLD;
	assign irq_set[ots_pkg::IRQ_TIMEOUT] = state_r == ots_pkg::ST_STEP
		&& state_nxt == ots_pkg::ST_DONE;
	assign irq_set[ots_pkg::IRQ_CFG_ERR] = state_r == ots_pkg::ST_DELAY
		&& state_nxt == ots_pkg::ST_DONE;

	// A set in the same cycle as a clear wins, so no event is lost.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= '0;
			irq_en_r <= '0;
		end else begin
			if (wr_go && s_axi_awaddr == ots_pkg::OFS_IRQ_CLR && s_axi_wstrb[0]) begin
				irq_stat_r <= (irq_stat_r & ~s_axi_wdata[ots_pkg::IRQ_W-1:0]) | irq_set;
			end else begin
				irq_stat_r <= irq_stat_r | irq_set;
			end
			if (wr_go && s_axi_awaddr == ots_pkg::OFS_IRQ_EN && s_axi_wstrb[0]) begin
				irq_en_r <= s_axi_wdata[ots_pkg::IRQ_W-1:0];
			end
		end
	end

	assign irq = |(irq_stat_r & irq_en_r);

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence s_start_seen;
		state_r == ots_pkg::ST_IDLE && run_ok;
	endsequence

	property p_start_needs_all;
		@(posedge aclk) disable iff (!aresetn)
		state_r == ots_pkg::ST_IDLE ##1 state_r == ots_pkg::ST_DELAY
			|-> $past(run_ok);
	endproperty
	a_start_needs_all: assert property (p_start_needs_all) else $error("start without enable");

	property p_delay_timer;
		@(posedge aclk) disable iff (!aresetn)
		s_start_seen |-> tmr.start && tmr.load_ms >= ots_pkg::DELAY_MS_MIN
			&& tmr.load_ms <= ots_pkg::DELAY_MS_MAX;
	endproperty
	a_delay_timer: assert property (p_delay_timer) else $error("bad start delay");

	property p_step_time;
		@(posedge aclk) disable iff (!aresetn)
		tmr.start && state_r != ots_pkg::ST_IDLE |-> tmr.load_ms >= ots_pkg::STEP_MS_MIN
			&& tmr.load_ms <= ots_pkg::STEP_MS_MAX;
	endproperty
	a_step_time: assert property (p_step_time) else $error("bad step time");

	property p_first_sp;
		@(posedge aclk) disable iff (!aresetn)
		state_r == ots_pkg::ST_DELAY && state_nxt == ots_pkg::ST_STEP && run_ok
			|=> sp_r == $past(c_start) ##1 sink_setpoint == $past(c_start, 2);
	endproperty
	a_first_sp: assert property (p_first_sp) else $error("ramp did not begin at start");

	property p_arm_voltage;
		@(posedge aclk) disable iff (!aresetn)
		state_r == ots_pkg::ST_DELAY && state_nxt == ots_pkg::ST_STEP |-> v_above;
	endproperty
	a_arm_voltage: assert property (p_arm_voltage) else $error("ramp began at low voltage");

	property p_trip_result;
		@(posedge aclk) disable iff (!aresetn)
		state_r == ots_pkg::ST_STEP && tmr.expired && v_below && meas_current <= c_end
			&& run_ok |=> code_r == ots_pkg::RES_TRIPPED && result_r == $past(sp_r)
			&& sp_r == $past(c_last);
	endproperty
	a_trip_result: assert property (p_trip_result) else $error("trip not reported");

	property p_timeout;
		@(posedge aclk) disable iff (!aresetn)
		state_r == ots_pkg::ST_STEP && tmr.expired && v_below && meas_current > c_end
			&& run_ok |=> code_r == ots_pkg::RES_TIMEOUT ##1 !sink_enable;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout not flagged");

	property p_cfg_err;
		@(posedge aclk) disable iff (!aresetn)
		state_r == ots_pkg::ST_DELAY && tmr.expired && !v_above && run_ok
			|=> code_r == ots_pkg::RES_CFG_ERR && state_r == ots_pkg::ST_DONE;
	endproperty
	a_cfg_err: assert property (p_cfg_err) else $error("config error not flagged");

	property p_one_code;
		@(posedge aclk) disable iff (!aresetn)
		code_r != ots_pkg::RES_NONE && !(state_r == ots_pkg::ST_IDLE && run_ok)
			|=> $stable(code_r) && $stable(result_r);
	endproperty
	a_one_code: assert property (p_one_code) else $error("result code changed");

	property p_hold_sink;
		@(posedge aclk) disable iff (!aresetn)
		state_r == ots_pkg::ST_HOLD && run_ok |=> sink_enable && sink_setpoint == $past(sp_r);
	endproperty
	a_hold_sink: assert property (p_hold_sink) else $error("post-trip load lost");
endmodule : ots_sequencer

// File: logic/ots_step_timer.sv
// Purpose: Millisecond interval timer for start delay and step periods.
// Assumes: TICK_CYCLES clocks make one millisecond.
// Notes: A new start pulse restarts the interval at once.
module ots_step_timer #(
	parameter int TICK_CYCLES = ots_pkg::TICK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	ots_tmr_if.tmr tmr
);
	logic [31:0] pre_r;
	logic [ots_pkg::MS_W-1:0] ms_r;
	logic run_r;
	logic exp_r;
	logic tick;

	// ************************************************************
	// Millisecond prescaler and countdown
	// ************************************************************
	// The prescaler restarts with each interval so the first tick is a full ms.
	assign tick = run_r && (pre_r == 32'(TICK_CYCLES - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn || tmr.start || tick) begin
			pre_r <= 32'h0;
		end else if (run_r) begin
			pre_r <= pre_r + 32'h1;
		end
	end

	// Countdown of whole milliseconds; expiry is a single pulse.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ms_r <= '0;
			run_r <= 1'b0;
			exp_r <= 1'b0;
		end else begin
			exp_r <= 1'b0;
			if (tmr.start) begin
				ms_r <= tmr.load_ms;
				run_r <= 1'b1;
			end else if (tick) begin
				ms_r <= ms_r - 1'b1;
				if (ms_r <= 21'd1) begin
					run_r <= 1'b0;
					exp_r <= 1'b1;
				end
			end
		end
	end

	assign tmr.expired = exp_r;
endmodule : ots_step_timer

// File: logic/ots_tmr_if.sv
// Purpose: Carries start, duration and expiry between sequencer and timer.
// Assumes: Both ends share aclk.
// Notes: start is a one-cycle pulse; expired is a one-cycle pulse.
interface ots_tmr_if;
	logic start;
	logic [ots_pkg::MS_W-1:0] load_ms;
	logic expired;
	modport ctl (output start, output load_ms, input expired);
	modport tmr (input start, input load_ms, output expired);
endinterface : ots_tmr_if

// File: verification/ots_supply_model.sv
// Purpose: Supply under test with overcurrent protection.
// Assumes: Shares aclk with the sequencer.
// Notes: A trip holds until reset or until the output is switched off.
module ots_supply_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic out_on,
	input wire logic [15:0] trip_level,
	input wire logic sink_enable,
	input wire logic [15:0] sink_setpoint,
	output logic [15:0] meas_voltage,
	output logic [15:0] meas_current
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tripped_r;
	// Protection latches once the load asks for the trip level or more.
	always_ff @(posedge aclk) begin
		if (!aresetn || !out_on) begin
			tripped_r <= 1'b0;
		end else if (sink_enable && sink_setpoint >= trip_level) begin
			tripped_r <= 1'b1;
		end
	end
	// A tripped or switched-off output collapses to zero volts.
	assign meas_voltage = (out_on && !tripped_r) ? 16'h1000 : 16'h0000;
	assign meas_current = sink_enable ? sink_setpoint : 16'h0000;
endmodule : ots_supply_model

// File: verification/overcurrent_trip_test_sequencer_bench.sv
// Purpose: Self-checking bench for the trip test sequencer.
// Assumes: TICK_CYCLES of 4 shortens a millisecond to four clocks.
// Notes: Ready signals are kept high, so the slave never stalls on us.
module overcurrent_trip_test_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, wv, rv, out_on, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, sink_enable, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, sink_range, rr;
	logic [7:0] addr;
	logic [31:0] wdata, s_axi_rdata, d;
	logic [15:0] trip_level, meas_voltage, meas_current, sink_setpoint;
	int fail_count = 0;
	int total_checks = 0;
	logic [31:0] cfg [8] = '{32'd10, 32'd100, 32'd10, 32'd5, 32'd50, 32'd5, 32'h100, 32'd1};
	ots_sequencer #(.TICK_CYCLES(4)) ots_sequencer_inst (.aclk, .aresetn,
		.s_axi_awaddr(addr), .s_axi_awvalid(wv), .s_axi_awready, .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready(1'b1), .s_axi_araddr(addr), .s_axi_arvalid(rv), .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .meas_voltage,
		.meas_current, .sink_enable, .sink_range, .sink_setpoint, .irq);
	ots_supply_model ots_supply_model_inst (.aclk, .aresetn, .out_on, .trip_level,
		.sink_enable, .sink_setpoint, .meas_voltage, .meas_current);
	// ************************************************************
	// Clock, bus tasks and checking
	// ************************************************************
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// Address and data stay put until the slave takes them together.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wv <= 1'b1;
		do @(posedge aclk); while (!s_axi_awready);
		wv <= 1'b0;
		do @(posedge aclk); while (!s_axi_bvalid);
		rr = s_axi_bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		addr <= a;
		rv <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		rv <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		rr = s_axi_rresp;
	endtask : rd
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Polls until the run settles; the watchdog bounds a run that never does.
	task automatic run(input logic [31:0] c);
		wr(ots_pkg::OFS_CTRL, c);
		do rd(ots_pkg::OFS_STATUS); while (d[5:0] != 6'h10 && d[5:0] != 6'h08);
		rd(ots_pkg::OFS_RESULT);
	endtask : run
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		close_out();
	end
	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		aresetn = 1'b0;
		{wv, rv, addr, wdata} = '0;
		out_on = 1'b1;
		trip_level = 16'd40;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		wr(ots_pkg::OFS_SETUP_BASE, 32'h77);
		wr(ots_pkg::OFS_CTRL, 32'h8);
		for (int i = 0; i < 8; i++) wr(ots_pkg::OFS_SETUP_BASE + 8'(4 * i), cfg[i]);
		wr(ots_pkg::OFS_CTRL, 32'h0);
		rd(ots_pkg::OFS_SETUP_BASE);
		chk(d, 32'h77);
		wr(ots_pkg::OFS_CTRL, 32'hb);
		repeat (60) @(posedge aclk);
		rd(ots_pkg::OFS_STATUS);
		chk(d, 32'h1);
		$display("test slots and mode done");
		run(32'hf);
		chk(d, 32'h0001_0028);
		chk(sink_setpoint, 32'd5);
		chk({sink_enable, sink_range}, 32'h5);
		chk(irq, 32'h0);
		wr(ots_pkg::OFS_IRQ_EN, 32'h7);
		chk(irq, 32'h1);
		wr(ots_pkg::OFS_IRQ_CLR, 32'h1);
		chk(irq, 32'h0);
		$display("test trip done");
		wr(ots_pkg::OFS_CTRL, 32'h0);
		trip_level <= 16'hffff;
		// The protection latch lets go only on reset or when the supply output is cycled.
		out_on <= 1'b0;
		@(posedge aclk);
		out_on <= 1'b1;
		run(32'hf);
		chk(d[17:16], 32'h2);
		rd(ots_pkg::OFS_IRQ_STAT);
		chk({d[30:0], irq}, 32'h5);
		$display("test timeout done");
		wr(ots_pkg::OFS_CTRL, 32'h0);
		out_on <= 1'b0;
		run(32'hf);
		chk({d[17:16], sink_enable}, 32'h6);
		rd(8'h40);
		chk(rr, ots_pkg::RESP_SLVERR);
		wr(8'h40, 32'h0);
		chk(rr, ots_pkg::RESP_SLVERR);
		$display("test config error done");
		close_out();
	end
endmodule : overcurrent_trip_test_sequencer_bench
